// >>> shared/fwdb_pkg.sv
// Constants and types for the firmware download serial bridge
package fwdb_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD = 115_200;
    localparam int BIT_CYC = CLK_HZ / BAUD;
    localparam int HALF_CYC = BIT_CYC / 2;
    localparam logic [15:0] BIT_CNT = 16'(BIT_CYC - 1);
    localparam logic [15:0] HALF_CNT = 16'(HALF_CYC - 1);
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h9;
    localparam int SUPPLY_MS = 100;
    localparam int TX_HIGH_MS = 50;
    localparam int PD_HOLD_MS = 3500;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int FIFO_AW = 3;
    localparam int FIFO_DEPTH = 8;
    localparam logic [FIFO_AW:0] FIFO_FULL = 4'h8;
    typedef enum logic [2:0] {
        FWDB_IDLE = 3'b000,
        FWDB_RELAY = 3'b001,
        FWDB_PD_HOLD = 3'b010,
        FWDB_IGN = 3'b011
    } fwdb_mode_t;
endpackage

// >>> src/fwdb_bridge.sv
// Host-side relay and control for reloading module firmware over serial
// What this block does
// - Module transmit line held high for 50 ms after supply rise, only when the supply rises in relay mode.
// - Transfer starts only after module completes its internal reset.
// - Relay PC receive to module transmit, module receive to PC transmit.
// - Forward each character with minimal latency at full rate.
// - Ports run at 115200 baud only.
// - Ignition released when DTR inactive, driven low when active.
// - Relay must run before the PC starts the transfer.
// - Power module off, start relay, then start PC transfer.
// - Restart: power-down low at least 3.5 s, then ignition.
// - Service connector takes module lines whenever plugged in, except during restart.
// - Own receivers idle and ignore input while connector used; transmitters drain buffered characters.
// - Allow for line driver inversion when reading line states.
`timescale 1ns/1ps
module fwdb_bridge #(
    parameter int SUPPLY_TO_CYC = fwdb_pkg::SUPPLY_MS * fwdb_pkg::MS_CYC,
    parameter int TX_HIGH_CYC = fwdb_pkg::TX_HIGH_MS * fwdb_pkg::MS_CYC,
    parameter int PD_HOLD_CYC = fwdb_pkg::PD_HOLD_MS * fwdb_pkg::MS_CYC,
    parameter logic INVERT_PC = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_relay_en,
    input wire logic i_restart,
    input wire logic i_pc_rx,
    input wire logic i_pc_dtr,
    output logic o_pc_tx,
    input wire logic i_mod_rx,
    output logic o_mod_tx,
    output logic o_ign_out,
    output logic o_ign_oe,
    output logic o_pd_out,
    output logic o_pd_oe,
    input wire logic i_mod_vdd,
    input wire logic i_svc_plugged,
    output logic o_relay_active,
    output logic o_supply_fault,
    output logic o_overflow
);
    import fwdb_pkg::*;

    typedef struct packed {
        logic [1:0] pc_rx_s;
        logic [1:0] mod_rx_s;
        logic [1:0] dtr_s;
        logic [1:0] vdd_s;
        logic [1:0] svc_s;
        logic vdd_d;
        fwdb_mode_t mode;
        logic [31:0] tmr;
        logic [31:0] tx_tmr;
        logic ign_low;
        logic pd_low;
        logic fault;
        logic ovf;
        logic [1:0] rx_busy;
        logic [1:0][15:0] rx_cnt;
        logic [1:0][3:0] rx_bit;
        logic [1:0][7:0] rx_sh;
        logic [1:0] tx_busy;
        logic [1:0][15:0] tx_cnt;
        logic [1:0][3:0] tx_bit;
        logic [1:0][9:0] tx_sh;
        logic [1:0] tx_line;
        logic [1:0][FIFO_DEPTH-1:0][7:0] mem;
        logic [1:0][FIFO_AW:0] wp;
        logic [1:0][FIFO_AW:0] rp;
    } fwdb_state_t;

    fwdb_state_t st_reg;
    fwdb_state_t st_next;
    logic [1:0] rx_line;
    logic relay_on;

    assign rx_line[0] = st_reg.pc_rx_s[1] ^ INVERT_PC;
    assign rx_line[1] = st_reg.mod_rx_s[1];
    assign relay_on = (st_reg.mode == FWDB_RELAY) && !st_reg.svc_s[1];

    always_comb begin
        st_next = st_reg;
        st_next.pc_rx_s = {st_reg.pc_rx_s[0], i_pc_rx};
        st_next.mod_rx_s = {st_reg.mod_rx_s[0], i_mod_rx};
        st_next.dtr_s = {st_reg.dtr_s[0], i_pc_dtr};
        st_next.vdd_s = {st_reg.vdd_s[0], i_mod_vdd};
        st_next.svc_s = {st_reg.svc_s[0], i_svc_plugged};
        st_next.vdd_d = st_reg.vdd_s[1];
        if (st_reg.tmr != 32'h0000_0000) begin
            st_next.tmr = st_reg.tmr - 32'h0000_0001;
        end
        if (st_reg.tx_tmr != 32'h0000_0000) begin
            st_next.tx_tmr = st_reg.tx_tmr - 32'h0000_0001;
        end
        case (st_reg.mode)
            FWDB_IDLE: begin
                st_next.ign_low = 1'b0;
                st_next.pd_low = 1'b0;
                if (i_relay_en) begin
                    st_next.mode = FWDB_RELAY;
                end else if (i_restart) begin
                    st_next.mode = FWDB_PD_HOLD;
                    st_next.tmr = 32'(PD_HOLD_CYC);
                end
            end
            FWDB_RELAY: begin
                st_next.ign_low = st_reg.dtr_s[1] ^ INVERT_PC;
                if (st_reg.svc_s[1]) begin
                    st_next.ign_low = 1'b0;
                end
                if (st_next.ign_low && !st_reg.ign_low) begin
                    st_next.tmr = 32'(SUPPLY_TO_CYC);
                end
                if (st_reg.ign_low && st_reg.tmr == 32'h0000_0001 && !st_reg.vdd_s[1]) begin
                    st_next.fault = 1'b1;
                end
                // hold line high after supply rise
                if (st_reg.vdd_s[1] && !st_reg.vdd_d) begin
                    st_next.tx_tmr = 32'(TX_HIGH_CYC);
                end
                if (!i_relay_en) begin
                    st_next.mode = FWDB_IDLE;
                end
            end
            FWDB_PD_HOLD: begin
                st_next.pd_low = 1'b1;
                if (st_reg.tmr == 32'h0000_0000 && st_reg.pd_low) begin
                    st_next.pd_low = 1'b0;
                    st_next.ign_low = 1'b1;
                    st_next.mode = FWDB_IGN;
                    st_next.tmr = 32'(SUPPLY_TO_CYC);
                end
            end
            FWDB_IGN: begin
                if (st_reg.tmr == 32'h0000_0000) begin
                    st_next.ign_low = 1'b0;
                    st_next.mode = FWDB_IDLE;
                end
            end
            default: begin
                st_next.mode = FWDB_IDLE;
            end
        endcase
        for (int l = 0; l < 2; l++) begin
            // 8N1 receiver, idle when connector plugged
            if (!relay_on) begin
                st_next.rx_busy[l] = 1'b0;
            end else if (!st_reg.rx_busy[l]) begin
                if (!rx_line[l]) begin
                    st_next.rx_busy[l] = 1'b1;
                    st_next.rx_cnt[l] = HALF_CNT;
                    st_next.rx_bit[l] = 4'h0;
                end
            end else if (st_reg.rx_cnt[l] != 16'h0000) begin
                st_next.rx_cnt[l] = st_reg.rx_cnt[l] - 16'h0001;
            end else begin
                st_next.rx_cnt[l] = BIT_CNT;
                st_next.rx_bit[l] = st_reg.rx_bit[l] + 4'h1;
                if (st_reg.rx_bit[l] == 4'h0 && rx_line[l]) begin
                    st_next.rx_busy[l] = 1'b0;
                end else if (st_reg.rx_bit[l] != 4'h0 && st_reg.rx_bit[l] <= DATA_BITS) begin
                    st_next.rx_sh[l] = {rx_line[l], st_reg.rx_sh[l][7:1]};
                end else if (st_reg.rx_bit[l] == LAST_BIT) begin
                    st_next.rx_busy[l] = 1'b0;
                    if (rx_line[l] && (st_reg.wp[l] - st_reg.rp[l]) != FIFO_FULL) begin
                        st_next.mem[l][st_reg.wp[l][FIFO_AW-1:0]] = st_reg.rx_sh[l];
                        st_next.wp[l] = st_reg.wp[l] + 4'h1;
                    end else if (rx_line[l]) begin
                        st_next.ovf = 1'b1;
                    end
                end
            end
            // forward to opposite port, start at once
            if (!st_reg.tx_busy[l]) begin
                st_next.tx_line[l] = 1'b1;
                if (st_reg.wp[l] != st_reg.rp[l]) begin
                    st_next.tx_busy[l] = 1'b1;
                    st_next.tx_sh[l] = {1'b1, st_reg.mem[l][st_reg.rp[l][FIFO_AW-1:0]], 1'b0};
                    st_next.rp[l] = st_reg.rp[l] + 4'h1;
                    st_next.tx_cnt[l] = BIT_CNT;
                    st_next.tx_bit[l] = 4'h0;
                end
            end else begin
                st_next.tx_line[l] = st_reg.tx_sh[l][0];
                if (st_reg.tx_cnt[l] != 16'h0000) begin
                    st_next.tx_cnt[l] = st_reg.tx_cnt[l] - 16'h0001;
                end else begin
                    st_next.tx_cnt[l] = BIT_CNT;
                    st_next.tx_sh[l] = {1'b1, st_reg.tx_sh[l][9:1]};
                    st_next.tx_bit[l] = st_reg.tx_bit[l] + 4'h1;
                    if (st_reg.tx_bit[l] == LAST_BIT) begin
                        st_next.tx_busy[l] = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '0;
            st_reg.pc_rx_s <= 2'h3;
            st_reg.mod_rx_s <= 2'h3;
            st_reg.tx_line <= 2'h3;
        end else begin
            st_reg <= st_next;
        end
    end

    // Lane 0 carries PC data to the module, lane 1 the reverse
    assign o_pc_tx = st_reg.tx_line[1] ^ INVERT_PC;
    // transmit line forced high in boot window
    assign o_mod_tx = st_reg.tx_line[0] | (st_reg.tx_tmr != 32'h0000_0000);
    assign o_ign_out = 1'b0;
    assign o_ign_oe = st_reg.ign_low;
    assign o_pd_out = 1'b0;
    assign o_pd_oe = st_reg.pd_low;
    assign o_relay_active = relay_on;
    assign o_supply_fault = st_reg.fault;
    assign o_overflow = st_reg.ovf;

    property ign_follows_dtr;
        @(posedge i_clk) disable iff (i_rst)
        (st_reg.mode == FWDB_RELAY && !st_reg.svc_s[1] && $stable(st_reg.dtr_s[1]))
            |=> (o_ign_oe == ($past(st_reg.dtr_s[1]) ^ INVERT_PC)) || st_reg.mode != FWDB_RELAY;
    endproperty
    ign_dtr_a: assert property (ign_follows_dtr) else $error("ignition not following DTR");

    svc_priority_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_reg.svc_s[1] && st_reg.mode == FWDB_RELAY |=> !o_ign_oe)
        else $error("ignition driven with connector");

    svc_rx_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_reg.svc_s[1] |=> st_reg.rx_busy == 2'h0) else $error("receiver busy in service");

    boot_high_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(st_reg.vdd_d) |-> o_mod_tx [*8]) else $error("module tx not held high");

    pd_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_pd_oe) |-> $past(st_reg.tmr) == 32'h0000_0000 && o_ign_oe)
        else $error("power-down released early");

    sequence tx_start_s;
        !st_reg.tx_busy[0] && st_reg.wp[0] != st_reg.rp[0];
    endsequence
    fwd_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
        tx_start_s |=> st_reg.tx_busy[0] ##1 !st_reg.tx_line[0])
        else $error("forward start late");

    no_overrun_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_reg.wp[0] - st_reg.rp[0]) <= FIFO_FULL) else $error("buffer overrun");

    stop_bit_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(st_reg.tx_busy[1]) |-> $past(st_reg.tx_line[1])) else $error("no stop bit");

    relay_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(st_reg.wp[1] != st_reg.rp[1]) |-> $past(relay_on, 2))
        else $error("character taken outside relay");

    fault_latch_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_supply_fault |=> o_supply_fault) else $error("supply fault cleared");

    watch_arm_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_ign_oe) && st_reg.mode == FWDB_RELAY |-> st_reg.tmr == 32'(SUPPLY_TO_CYC))
        else $error("supply watchdog not armed");

    sequence pd_entry_s;
        st_reg.mode == FWDB_PD_HOLD && st_reg.tmr == 32'(PD_HOLD_CYC) ##1 o_pd_oe;
    endsequence
    restart_entry_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_reg.mode == FWDB_IDLE && !i_relay_en && i_restart |=> pd_entry_s)
        else $error("restart did not pull power-down");

    restart_ign_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_reg.mode == FWDB_IGN |-> o_ign_oe && !o_pd_oe)
        else $error("ignition not driven after power-down");

    idle_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_reg.mode == FWDB_IDLE && $past(st_reg.mode) == FWDB_IDLE |-> !o_ign_oe && !o_pd_oe)
        else $error("pin driven while idle");

    // Full flag per lane, only for the overflow check
    logic [1:0] lane_full;
    for (genvar g = 0; g < 2; g++) begin : g_lane_full
        assign lane_full[g] = (st_reg.wp[g] - st_reg.rp[g]) == FIFO_FULL;
    end
    ovf_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_overflow) |-> $past(lane_full) != 2'h0)
        else $error("overflow without full buffer");

    tx_idle_high_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !$past(st_reg.tx_busy[1]) |-> st_reg.tx_line[1])
        else $error("line not idle high");

    sequence back_start_s;
        !st_reg.tx_busy[1] && st_reg.wp[1] != st_reg.rp[1];
    endsequence
    back_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
        back_start_s |=> st_reg.tx_busy[1] ##1 !st_reg.tx_line[1])
        else $error("reverse forward start late");
endmodule

// >>> verif/fwdb_bridge_tb_top.sv
// Self-checking bench for the firmware download serial bridge
`timescale 1ns/1ps
module fwdb_bridge_tb_top;
    import fwdb_pkg::*;
    logic i_clk, i_rst, i_relay_en, i_restart, i_pc_rx, i_pc_dtr, i_svc_plugged;
    logic o_pc_tx, o_mod_tx, o_ign_out, o_ign_oe, o_pd_out, o_pd_oe;
    logic o_relay_active, o_supply_fault, o_overflow, mod_vdd, mod_line, m_slow, m_send;
    logic [7:0] m_data;
    wire ign_line = o_ign_oe ? o_ign_out : 1'b1;
    wire pd_line = o_pd_oe ? o_pd_out : 1'b1;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    fwdb_bridge #(.SUPPLY_TO_CYC(50), .TX_HIGH_CYC(20), .PD_HOLD_CYC(100), .INVERT_PC(1'b0))
    fwdb_bridge_i (.i_clk(i_clk), .i_rst(i_rst), .i_relay_en(i_relay_en),
        .i_restart(i_restart), .i_pc_rx(i_pc_rx), .i_pc_dtr(i_pc_dtr), .o_pc_tx(o_pc_tx),
        .i_mod_rx(mod_line), .o_mod_tx(o_mod_tx), .o_ign_out(o_ign_out), .o_ign_oe(o_ign_oe),
        .o_pd_out(o_pd_out), .o_pd_oe(o_pd_oe), .i_mod_vdd(mod_vdd),
        .i_svc_plugged(i_svc_plugged), .o_relay_active(o_relay_active),
        .o_supply_fault(o_supply_fault), .o_overflow(o_overflow));
    fwdb_module_model fwdb_module_model_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_ign_line(ign_line), .i_pd_line(pd_line), .i_slow(m_slow), .i_send(m_send),
        .i_data(m_data), .o_vdd(mod_vdd), .o_tx(mod_line));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Whole run needs about 5500 cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            $display("unexpected at %0t: run hung", $time);
            close_out;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic line(input bit sel);
        return sel ? o_pc_tx : o_mod_tx;
    endfunction
    task automatic pc_send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int b = 0; b < 10; b++) begin
            @(posedge i_clk) i_pc_rx <= f[b];
            repeat (BIT_CYC - 1) @(posedge i_clk);
        end
    endtask
    // Samples mid-bit, so a one-cycle bit length slip stays harmless
    task automatic line_get(input bit sel, output logic [7:0] d);
        int n;
        n = 0;
        d = 8'hxx;
        while (line(sel) !== 1'b0 && n < 3000) begin
            @(negedge i_clk);
            n++;
        end
        repeat (HALF_CYC) @(negedge i_clk);
        for (int b = 0; b < 9; b++) begin
            repeat (BIT_CYC) @(negedge i_clk);
            if (b < 8) d[b] = line(sel);
        end
    endtask
    task automatic do_reset;
        @(posedge i_clk) i_rst <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic t_reset;
        @(negedge i_clk);
        check({o_pc_tx, o_mod_tx}, 8'h03);
        check({o_ign_oe, o_pd_oe, o_relay_active}, 8'h00);
        check({o_supply_fault, o_overflow}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_ignite;
        int n;
        int lows;
        lows = 0;
        @(posedge i_clk) i_relay_en <= 1'b1;
        repeat (10) @(negedge i_clk);
        check(o_relay_active, 8'h01);
        check(o_ign_oe, 8'h00);
        @(posedge i_clk) i_pc_dtr <= 1'b1;
        n = 0;
        while (mod_vdd !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        check({o_ign_oe, o_ign_out}, 8'h02);
        repeat (20) begin
            @(negedge i_clk);
            lows += (o_mod_tx !== 1'b1);
        end
        check(lows > 0, 8'h00);
        repeat (60) @(negedge i_clk);
        check(o_supply_fault, 8'h00);
        $display("test ignite done");
    endtask
    task automatic t_relay;
        logic [7:0] a, b, c, d;
        fork
            begin pc_send(8'hA5); pc_send(8'h3C); end
            begin line_get(1'b0, a); line_get(1'b0, b); end
        join
        check(a, 8'hA5);
        check(b, 8'h3C);
        fork
            pc_send(8'h81);
            begin @(posedge i_clk) m_send <= 1'b1; @(posedge i_clk) m_send <= 1'b0; end
            line_get(1'b0, c);
            line_get(1'b1, d);
        join
        check(c, 8'h81);
        check(d, 8'h7E);
        check(o_overflow, 8'h00);
        $display("test relay done");
    endtask
    task automatic t_service;
        int lows;
        lows = 0;
        @(posedge i_clk) i_svc_plugged <= 1'b1;
        repeat (5) @(negedge i_clk);
        check(o_ign_oe, 8'h00);
        fork
            pc_send(8'h00);
            repeat (11 * BIT_CYC) begin
                @(negedge i_clk);
                lows += (o_mod_tx !== 1'b1);
            end
        join
        check(lows > 0, 8'h00);
        @(posedge i_clk) i_svc_plugged <= 1'b0;
        $display("test service done");
    endtask
    task automatic t_restart;
        int n;
        @(posedge i_clk) i_relay_en <= 1'b0;
        i_pc_dtr <= 1'b0;
        repeat (5) @(posedge i_clk);
        i_restart <= 1'b1;
        @(posedge i_clk) i_restart <= 1'b0;
        n = 0;
        while (o_pd_oe !== 1'b1 && n < 10) begin
            @(negedge i_clk);
            n++;
        end
        check({o_pd_oe, o_pd_out, o_ign_oe}, 8'h04);
        n = 0;
        while (o_pd_oe === 1'b1 && n < 400) begin
            @(negedge i_clk);
            n++;
        end
        check(n >= 100 && n < 400, 8'h01);
        repeat (3) @(negedge i_clk);
        check({o_ign_oe, o_ign_out}, 8'h02);
        $display("test restart done");
    endtask
    task automatic t_fault;
        @(posedge i_clk) m_slow <= 1'b1;
        do_reset;
        i_relay_en <= 1'b1;
        i_pc_dtr <= 1'b1;
        repeat (40) @(negedge i_clk);
        check(o_supply_fault, 8'h00);
        repeat (40) @(negedge i_clk);
        check({o_supply_fault, mod_vdd}, 8'h02);
        $display("test fault done");
    endtask
    initial begin
        i_rst = 1'b1;
        i_relay_en = 1'b0;
        i_restart = 1'b0;
        i_pc_rx = 1'b1;
        i_pc_dtr = 1'b0;
        i_svc_plugged = 1'b0;
        m_slow = 1'b0;
        m_send = 1'b0;
        m_data = 8'h7E;
        do_reset;
        t_reset;
        t_ignite;
        t_relay;
        t_service;
        t_restart;
        t_fault;
        close_out;
    end
endmodule

// >>> verif/fwdb_module_model.sv
// Behavioural model of the cellular module beyond the bridge
`timescale 1ns/1ps
module fwdb_module_model
    import fwdb_pkg::*;
#(
    parameter int FAST_CYC = 10,
    parameter int SLOW_CYC = 80
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ign_line,
    input wire logic i_pd_line,
    input wire logic i_slow,
    input wire logic i_send,
    input wire logic [7:0] i_data,
    output logic o_vdd,
    output logic o_tx
);
    logic ign_q;
    int wait_cnt;
    int phase;
    int bits;
    logic [9:0] frame;
    // Model drives the line high itself when nothing is sent
    assign o_tx = (bits != 0) ? frame[0] : 1'b1;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ign_q <= 1'b1;
            wait_cnt <= 0;
            o_vdd <= 1'b0;
            phase <= 0;
            bits <= 0;
            frame <= '1;
        end else begin
            ign_q <= i_ign_line;
            if (!i_pd_line) begin
                o_vdd <= 1'b0;
                wait_cnt <= 0;
            end else if (ign_q && !i_ign_line && !o_vdd) begin
                wait_cnt <= 1;
            end else if (wait_cnt != 0 && !o_vdd) begin
                wait_cnt <= wait_cnt + 1;
                o_vdd <= (wait_cnt >= (i_slow ? SLOW_CYC : FAST_CYC));
            end
            if (bits == 0 && i_send && o_vdd) begin
                frame <= {1'b1, i_data, 1'b0};
                bits <= 10;
                phase <= 0;
            end else if (bits != 0) begin
                phase <= (phase == BIT_CYC - 1) ? 0 : phase + 1;
                if (phase == BIT_CYC - 1) begin
                    frame <= {1'b1, frame[9:1]};
                    bits <= bits - 1;
                end
            end
        end
    end
endmodule
